// ### design/fft_pkg.sv
// Purpose: shared constants and helpers for the 256-point transform engine
// Assumes: two's complement data, one clock
// Notes:   frame size, rank count and bank count are fixed by the algorithm
package fft_pkg;
  localparam int          DATA_W       = 16;
  localparam int          N_POINTS     = 256;
  localparam int          N_RANKS      = 4;
  localparam int          N_BFLY       = 64;
  localparam int          N_STEPS      = 8;
  localparam int          N_BANKS      = 3;
  localparam int          FRAME_CYCLES = N_RANKS * N_BFLY * N_STEPS;
  localparam logic [1:0]  MODE_SINGLE  = 2'h0;
  localparam logic [1:0]  MODE_DOUBLE  = 2'h1;
  localparam logic [1:0]  MODE_TRIPLE  = 2'h2;
  localparam logic [2:0]  SHIFT_PASS   = 3'h2;
  localparam logic [2:0]  SHIFT_FIRST  = 3'h3;
  localparam logic [2:0]  STEP_LAST    = 3'h7;
  localparam logic [5:0]  BFLY_LAST    = 6'h3f;
  localparam logic [1:0]  RANK_FIRST   = 2'h0;
  localparam logic [1:0]  RANK_LAST    = 2'h3;
  localparam logic [7:0]  COUNT_LAST   = 8'hff;
  localparam logic [1:0]  BANK_A       = 2'h0;
  localparam logic [1:0]  BANK_B       = 2'h1;
  localparam logic [1:0]  BANK_C       = 2'h2;
  localparam logic [11:0] CYCLES_FRAME = 12'h800;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CALC} state_type;

  // location of one of the four legs of a dragonfly, in place
  function automatic logic [7:0] bfly_addr(input logic [1:0] rank,
                                           input logic [5:0] bfly,
                                           input logic [1:0] leg);
    case (rank)
      2'h0:    return {leg, bfly};
      2'h1:    return {bfly[5:4], leg, bfly[3:0]};
      2'h2:    return {bfly[5:2], leg, bfly[1:0]};
      default: return {bfly, leg};
    endcase
  endfunction : bfly_addr

  // base-4 digit reversal, maps natural index to stored location
  function automatic logic [7:0] digit_rev(input logic [7:0] idx);
    return {idx[1:0], idx[3:2], idx[5:4], idx[7:6]};
  endfunction : digit_rev
endpackage : fft_pkg

// ### design/twiddle_gen.sv
// Purpose: twiddle factor for one angle step of a 256-point circle
// Assumes: angle in units of 2*pi/256
// Notes:   quarter-wave table, full scale 32767
`timescale 1ns/1ns
module twiddle_gen (
  input  wire logic [7:0]  angle,
  input  wire logic        inverse,
  output logic      [15:0] w_re,
  output logic      [15:0] w_im
);
  localparam logic [15:0] QSIN [65] = '{
    16'h0000, 16'h0324, 16'h0648, 16'h096a, 16'h0c8c, 16'h0fab, 16'h12c8, 16'h15e2,
    16'h18f9, 16'h1c0b, 16'h1f1a, 16'h2223, 16'h2528, 16'h2826, 16'h2b1f, 16'h2e11,
    16'h30fb, 16'h33df, 16'h36ba, 16'h398c, 16'h3c56, 16'h3f17, 16'h41ce, 16'h447a,
    16'h471c, 16'h49b4, 16'h4c3f, 16'h4ebf, 16'h5133, 16'h539b, 16'h55f5, 16'h5842,
    16'h5a82, 16'h5cb4, 16'h5ed7, 16'h60ec, 16'h62f1, 16'h64e8, 16'h66cf, 16'h68a6,
    16'h6a6d, 16'h6c24, 16'h6dc9, 16'h6f5e, 16'h70e2, 16'h7254, 16'h73b5, 16'h7504,
    16'h7641, 16'h776b, 16'h7884, 16'h7989, 16'h7a7c, 16'h7b5c, 16'h7c29, 16'h7ce3,
    16'h7d89, 16'h7e1d, 16'h7e9c, 16'h7f09, 16'h7f61, 16'h7fa6, 16'h7fd8, 16'h7ff5,
    16'h7fff};

  logic [6:0]  r;
  logic [6:0]  rc;
  logic [15:0] cosv;
  logic [15:0] sinv;

  always_comb begin
    r  = {1'b0, angle[5:0]};
    rc = 7'h40 - r;
    case (angle[7:6])
      2'h0: begin
        cosv = QSIN[rc];
        sinv = QSIN[r];
      end
      2'h1: begin
        cosv = 16'h0000 - QSIN[r];
        sinv = QSIN[rc];
      end
      2'h2: begin
        cosv = 16'h0000 - QSIN[rc];
        sinv = 16'h0000 - QSIN[r];
      end
      default: begin
        cosv = QSIN[r];
        sinv = 16'h0000 - QSIN[rc];
      end
    endcase
    w_re = cosv;
    w_im = inverse ? sinv : 16'h0000 - sinv;
  end
endmodule : twiddle_gen

// ### design/dragonfly.sv
// Purpose: radix-4 decimation-in-frequency dragonfly with per-pass scaling
// Assumes: legs 1..3 get their twiddles from outside
// Notes:   purely combinational; scaling before the twiddle keeps 16-bit products
`timescale 1ns/1ns
module dragonfly (
  input  wire logic [3:0][15:0] x_re,
  input  wire logic [3:0][15:0] x_im,
  input  wire logic [2:0][15:0] w_re,
  input  wire logic [2:0][15:0] w_im,
  input  wire logic             inverse,
  input  wire logic             extra,
  output logic      [3:0][15:0] y_re,
  output logic      [3:0][15:0] y_im
);
  function automatic logic signed [17:0] ext(input logic [15:0] v);
    return 18'($signed(v));
  endfunction : ext

  // a*b -/+ c*d in q15, dropped bits go by arithmetic shift
  function automatic logic [15:0] mac(input logic [15:0] a, input logic [15:0] b,
                                      input logic [15:0] c, input logic [15:0] d,
                                      input logic sub);
    logic signed [32:0] p;
    p = 33'($signed(a) * $signed(b));
    p = sub ? p - 33'($signed(c) * $signed(d)) : p + 33'($signed(c) * $signed(d));
    return p[30:15];
  endfunction : mac

  logic signed [17:0] ar, ai, br, bi, cr, ci, dr, di;
  logic [3:0][17:0]   sr;
  logic [3:0][17:0]   si;
  logic [3:0][15:0]   zr;
  logic [3:0][15:0]   zi;
  logic [2:0]         sh;

  always_comb begin
    ar = ext(x_re[0]) + ext(x_re[2]);
    ai = ext(x_im[0]) + ext(x_im[2]);
    br = ext(x_re[0]) - ext(x_re[2]);
    bi = ext(x_im[0]) - ext(x_im[2]);
    cr = ext(x_re[1]) + ext(x_re[3]);
    ci = ext(x_im[1]) + ext(x_im[3]);
    dr = ext(x_re[1]) - ext(x_re[3]);
    di = ext(x_im[1]) - ext(x_im[3]);
    sr[0] = ar + cr;
    si[0] = ai + ci;
    sr[2] = ar - cr;
    si[2] = ai - ci;
    if (inverse) begin
      sr[1] = br - di;
      si[1] = bi + dr;
      sr[3] = br + di;
      si[3] = bi - dr;
    end else begin
      sr[1] = br + di;
      si[1] = bi - dr;
      sr[3] = br - di;
      si[3] = bi + dr;
    end
    sh = extra ? fft_pkg::SHIFT_FIRST : fft_pkg::SHIFT_PASS;
    for (int m = 0; m < 4; m++) begin
      zr[m] = 16'($signed(sr[m]) >>> sh);
      zi[m] = 16'($signed(si[m]) >>> sh);
    end
    y_re[0] = zr[0];
    y_im[0] = zi[0];
    for (int m = 1; m < 4; m++) begin
      y_re[m] = mac(zr[m], w_re[m-1], zi[m], w_im[m-1], 1'b1);
      y_im[m] = mac(zr[m], w_im[m-1], zi[m], w_re[m-1], 1'b0);
    end
  end
endmodule : dragonfly

// ### design/fft256_engine.sv
// Purpose: 256-point complex forward/inverse transform, in place, radix-4
// Assumes: every input synchronous to mclk; nrst asynchronous, active low
// Notes:   three internal frame banks; io_mode picks single, double or triple use
//
// Overview of operation
// - forward or inverse transform, 256 points
// - real and imaginary 16-bit two's complement
// - radix-4 decimation in frequency dragonflies
// - four ranks of 64 dragonflies
// - results go back to read locations
// - every pass divides results by four
// - scale select adds shift, first pass
// - output scaled 1/256 or 1/512
// - extra shift at first-rank write
// - scale select same both directions
// - inverse uses positive exponent kernel
// - twiddles generated inside, 16 bits
// - engine drives all memory addresses, enables
// - load, transform, unload overlap
// - three selectable memory arrangements
// - natural order input and output
// - options sampled when start taken
// - continuous modes resample direction, scale each frame
`timescale 1ns/1ns
module fft256_engine (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        direction_select,
  input  wire logic        scale_select,
  input  wire logic [1:0]  io_mode,
  input  wire logic        in_write,
  input  wire logic [15:0] din_r,
  input  wire logic [15:0] din_i,
  input  wire logic        out_read,
  output logic      [15:0] dout_r,
  output logic      [15:0] dout_i,
  output logic      [7:0]  dout_index,
  output logic             dout_valid,
  output logic      [7:0]  in_index,
  output logic             in_ready,
  output logic             busy,
  output logic             done,
  output logic             mode_latch,
  output logic      [1:0]  bank
);
  fft_pkg::state_type state;
  logic                nrst_meta;
  logic                nrst_sync;
  logic [1:0]          rank;
  logic [5:0]          bfly;
  logic [2:0]          step;
  logic                dir_lat;
  logic                scale_lat;
  logic [1:0]          mode_lat;
  logic [1:0]          mode_now;
  logic [1:0]          in_bank;
  logic [1:0]          calc_bank;
  logic [1:0]          out_bank;
  logic [7:0]          in_count;
  logic [7:0]          out_count;
  logic                frame_ready;
  logic                in_take;
  logic                out_take;
  logic                start_take;
  logic                rotate;
  logic                frame_end;
  logic                calc_rd;
  logic                calc_we;
  logic                first_extra;
  logic [7:0]          calc_addr;
  logic [7:0]          tw_base;
  logic [2:0][7:0]     tw_exp;
  logic [2:0][15:0]    tw_re;
  logic [2:0][15:0]    tw_im;
  logic [3:0][15:0]    x_re;
  logic [3:0][15:0]    x_im;
  logic [3:0][15:0]    y_re;
  logic [3:0][15:0]    y_im;
  logic [31:0]         mem [fft_pkg::N_BANKS][fft_pkg::N_POINTS];
  logic [11:0]         calc_cycles;
  logic [3:0][7:0]     rd_hist;
  logic signed [17:0]  dc_sum;

  // reset release is synchronised, assertion stays asynchronous
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      nrst_meta <= 1'b0;
      nrst_sync <= 1'b0;
    end else begin
      nrst_meta <= 1'b1;
      nrst_sync <= nrst_meta;
    end
  end

  // while running, the latched arrangement governs the ports
  assign mode_now    = (state == fft_pkg::ST_IDLE) ? io_mode : mode_lat;
  assign start_take  = ce && start && (state == fft_pkg::ST_IDLE);
  assign rotate      = ce && (state == fft_pkg::ST_WAIT) && frame_ready;
  assign calc_rd     = (state == fft_pkg::ST_CALC) && !step[2];
  assign calc_we     = ce && (state == fft_pkg::ST_CALC) && step[2];
  assign frame_end   = calc_we && (step == fft_pkg::STEP_LAST)
                       && (bfly == fft_pkg::BFLY_LAST) && (rank == fft_pkg::RANK_LAST);
  assign first_extra = scale_lat && (rank == fft_pkg::RANK_FIRST);
  assign calc_addr   = fft_pkg::bfly_addr(rank, bfly, step[1:0]);
  assign in_ready    = (mode_now == fft_pkg::MODE_SINGLE) ?
                       (state == fft_pkg::ST_IDLE) : !frame_ready;
  assign in_take     = ce && in_write && in_ready;
  assign out_take    = ce && out_read
                       && ((mode_now != fft_pkg::MODE_SINGLE) || (state == fft_pkg::ST_IDLE));
  assign busy        = (state == fft_pkg::ST_CALC);
  assign bank        = calc_bank;
  assign in_index    = in_count;

  // twiddle step k * 4^rank, legs use 1x, 2x, 3x of it
  always_comb begin
    case (rank)
      2'h0:    tw_base = {2'h0, bfly};
      2'h1:    tw_base = {2'h0, bfly[3:0], 2'h0};
      2'h2:    tw_base = {2'h0, bfly[1:0], 4'h0};
      default: tw_base = 8'h00;
    endcase
    tw_exp[0] = tw_base;
    tw_exp[1] = {tw_base[6:0], 1'b0};
    tw_exp[2] = tw_base + {tw_base[6:0], 1'b0};
  end

  for (genvar m = 0; m < 3; m++) begin : g_tw
    twiddle_gen u_tw (
      .angle   (tw_exp[m]),
      .inverse (!dir_lat),
      .w_re    (tw_re[m]),
      .w_im    (tw_im[m])
    );
  end

  dragonfly u_dfly (
    .x_re    (x_re),
    .x_im    (x_im),
    .w_re    (tw_re),
    .w_im    (tw_im),
    .inverse (!dir_lat),
    .extra   (first_extra),
    .y_re    (y_re),
    .y_im    (y_im)
  );

  // sequencer: 4 ranks x 64 dragonflies x (4 reads + 4 writes)
  always_ff @(posedge mclk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      state <= fft_pkg::ST_IDLE;
      rank  <= 2'h0;
      bfly  <= 6'h00;
      step  <= 3'h0;
    end else if (ce) begin
      case (state)
        fft_pkg::ST_IDLE: begin
          if (start) begin
            state <= (io_mode == fft_pkg::MODE_SINGLE) ? fft_pkg::ST_CALC : fft_pkg::ST_WAIT;
          end
        end
        fft_pkg::ST_WAIT: begin
          if (frame_ready) begin
            state <= fft_pkg::ST_CALC;
          end
        end
        fft_pkg::ST_CALC: begin
          step <= step + 3'h1;
          if (step == fft_pkg::STEP_LAST) begin
            bfly <= bfly + 6'h01;
            if (bfly == fft_pkg::BFLY_LAST) begin
              rank <= rank + 2'h1;
              if (rank == fft_pkg::RANK_LAST) begin
                state <= (mode_lat == fft_pkg::MODE_SINGLE) ? fft_pkg::ST_IDLE
                                                            : fft_pkg::ST_WAIT;
              end
            end
          end
        end
        default: state <= fft_pkg::ST_IDLE;
      endcase
    end
  end

  // option latches
  always_ff @(posedge mclk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      dir_lat    <= 1'b1;
      scale_lat  <= 1'b0;
      mode_lat   <= fft_pkg::MODE_SINGLE;
      mode_latch <= 1'b0;
    end else if (ce) begin
      mode_latch <= rotate;
      if (start_take) begin
        dir_lat   <= direction_select;
        scale_lat <= scale_select;
        mode_lat  <= io_mode;
      end else if (rotate) begin
        dir_lat   <= direction_select;
        scale_lat <= scale_select;
      end
    end
  end

  // bank roles: input, transform, output
  always_ff @(posedge mclk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      in_bank   <= fft_pkg::BANK_A;
      calc_bank <= fft_pkg::BANK_B;
      out_bank  <= fft_pkg::BANK_C;
    end else if (start_take) begin
      case (io_mode)
        fft_pkg::MODE_SINGLE: begin
          in_bank   <= fft_pkg::BANK_A;
          calc_bank <= fft_pkg::BANK_A;
          out_bank  <= fft_pkg::BANK_A;
        end
        fft_pkg::MODE_DOUBLE: begin
          in_bank   <= fft_pkg::BANK_A;
          calc_bank <= fft_pkg::BANK_B;
          out_bank  <= fft_pkg::BANK_A;
        end
        default: begin
          in_bank   <= fft_pkg::BANK_A;
          calc_bank <= fft_pkg::BANK_B;
          out_bank  <= fft_pkg::BANK_C;
        end
      endcase
    end else if (rotate) begin
      calc_bank <= in_bank;
      out_bank  <= calc_bank;
      in_bank   <= (mode_lat == fft_pkg::MODE_DOUBLE) ? calc_bank : out_bank;
    end
  end

  // loader; frame_ready set beats its clear
  always_ff @(posedge mclk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      in_count    <= 8'h00;
      frame_ready <= 1'b0;
    end else if (ce) begin
      if (rotate) begin
        frame_ready <= 1'b0;
      end
      if (in_take) begin
        in_count <= in_count + 8'h01;
        if ((in_count == fft_pkg::COUNT_LAST) && (mode_now != fft_pkg::MODE_SINGLE)) begin
          frame_ready <= 1'b1;
        end
      end
    end
  end

  // sample storage; no reset, contents are data only
  always_ff @(posedge mclk) begin
    if (in_take) begin
      mem[in_bank][in_count] <= {din_r, din_i};
    end
    if (calc_we) begin
      mem[calc_bank][calc_addr] <= {y_re[step[1:0]], y_im[step[1:0]]};
    end
  end

  // dragonfly operand registers
  always_ff @(posedge mclk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      x_re <= '0;
      x_im <= '0;
    end else if (ce && calc_rd) begin
      x_re[step[1:0]] <= mem[calc_bank][calc_addr][31:16];
      x_im[step[1:0]] <= mem[calc_bank][calc_addr][15:0];
    end
  end

  // unloader; stored order is digit reversed, so undo it on the way out
  always_ff @(posedge mclk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      out_count  <= 8'h00;
      dout_r     <= 16'h0000;
      dout_i     <= 16'h0000;
      dout_index <= 8'h00;
      dout_valid <= 1'b0;
    end else if (ce) begin
      dout_valid <= out_take;
      if (start_take || rotate) begin
        out_count <= 8'h00;
      end else if (out_take) begin
        out_count  <= out_count + 8'h01;
        dout_index <= out_count;
        dout_r     <= mem[out_bank][fft_pkg::digit_rev(out_count)][31:16];
        dout_i     <= mem[out_bank][fft_pkg::digit_rev(out_count)][15:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      done <= 1'b0;
    end else if (ce) begin
      done <= frame_end;
    end
  end

  // helpers read only by the checks below
  always_ff @(posedge mclk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      calc_cycles <= 12'h000;
      rd_hist     <= '0;
    end else if (ce) begin
      calc_cycles <= busy ? calc_cycles + 12'h001 : 12'h000;
      if (calc_rd) begin
        rd_hist[step[1:0]] <= calc_addr;
      end
    end
  end

  assign dc_sum = 18'($signed(x_re[0])) + 18'($signed(x_re[1]))
                + 18'($signed(x_re[2])) + 18'($signed(x_re[3]));

  AST_START_LATCH: assert property (
    @(posedge mclk) disable iff (!nrst_sync)
    start_take |=> (dir_lat == $past(direction_select)) && (scale_lat == $past(scale_select)))
    else $error("options not sampled at start");

  AST_RELATCH: assert property (
    @(posedge mclk) disable iff (!nrst_sync)
    rotate |=> mode_latch && (scale_lat == $past(scale_select))
               && (dir_lat == $past(direction_select)))
    else $error("options not resampled at frame change");

  AST_FRAME_CYCLES: assert property (
    @(posedge mclk) disable iff (!nrst_sync)
    $rose(done) |-> (calc_cycles == fft_pkg::CYCLES_FRAME))
    else $error("frame did not take 4 ranks of 64 dragonflies");

  AST_IN_PLACE: assert property (
    @(posedge mclk) disable iff (!nrst_sync)
    calc_we |-> (calc_addr == rd_hist[step[1:0]]))
    else $error("result written away from its source");

  AST_DC_SCALE: assert property (
    @(posedge mclk) disable iff (!nrst_sync)
    (calc_we && step[1:0] == 2'h0) |->
      y_re[0] == 16'(dc_sum >>> (first_extra ? fft_pkg::SHIFT_FIRST : fft_pkg::SHIFT_PASS)))
    else $error("leg 0 not scaled by the pass factor");

  AST_EXTRA_FIRST: assert property (
    @(posedge mclk) disable iff (!nrst_sync)
    (calc_we && step[1:0] == 2'h0 && rank != fft_pkg::RANK_FIRST) |->
      y_re[0] == 16'(dc_sum >>> fft_pkg::SHIFT_PASS))
    else $error("extra shift outside first rank");

  AST_DONE_PULSE: assert property (
    @(posedge mclk) disable iff (!nrst_sync)
    (done && ce) |=> !done)
    else $error("done longer than one cycle");

  AST_OUT_ORDER: assert property (
    @(posedge mclk) disable iff (!nrst_sync)
    (out_take && !rotate) |=> dout_valid && (dout_index == $past(out_count)))
    else $error("result not delivered in index order");

  AST_FRAME_HOLD: assert property (
    @(posedge mclk) disable iff (!nrst_sync)
    (ce && state == fft_pkg::ST_WAIT && !frame_ready) |=> (state == fft_pkg::ST_WAIT))
    else $error("transform began without a full frame");

  AST_BANKS_APART: assert property (
    @(posedge mclk) disable iff (!nrst_sync)
    (busy && mode_lat == fft_pkg::MODE_TRIPLE) |->
      (in_bank != calc_bank) && (calc_bank != out_bank) && (in_bank != out_bank))
    else $error("triple arrangement banks overlap");
endmodule : fft256_engine

// ### bench/fft_user_model.sv
// Purpose: user logic on the far side: loads frames, reads results back
// Assumes: drives on the falling edge of mclk, write strobes checked against in_ready, read strobes unchecked
// Notes:   stalls at random; an idle data bus shows inverted stale values
`timescale 1ns/1ns
module fft_user_model (
  input  wire logic        mclk,
  input  wire logic        in_ready,
  input  wire logic [15:0] dout_r,
  input  wire logic [15:0] dout_i,
  input  wire logic [7:0]  dout_index,
  input  wire logic        dout_valid,
  output logic             in_write,
  output logic      [15:0] din_r,
  output logic      [15:0] din_i,
  output logic             out_read
);
  logic [15:0] fr [256];
  logic [15:0] fi [256];
  logic [15:0] rr [256];
  logic [15:0] ri [256];
  logic [7:0]  ix [256];
  int          nres;

  initial begin
    in_write = 1'b0;
    out_read = 1'b0;
    din_r    = 16'h0;
    din_i    = 16'h0;
    nres     = 0;
  end

  // results kept in arrival order so ordering can be judged
  always @(posedge mclk) begin
    if (dout_valid && nres < 256) begin
      rr[nres] = dout_r;
      ri[nres] = dout_i;
      ix[nres] = dout_index;
      nres++;
    end
  end

  task automatic load();
    int i;
    i = 0;
    while (i < 256) begin
      @(negedge mclk);
      if ($urandom % 5 == 0) begin
        in_write = 1'b0;
        din_r    = ~din_r;
        din_i    = ~din_i;
      end else begin
        in_write = 1'b1;
        din_r    = fr[i];
        din_i    = fi[i];
        #1;
        if (in_ready) i++;
      end
    end
    @(negedge mclk);
    in_write = 1'b0;
    din_r    = ~din_r;
    din_i    = ~din_i;
  endtask : load

  task automatic unload();
    int k;
    k    = 0;
    nres = 0;
    while (k < 256) begin
      @(negedge mclk);
      out_read = ($urandom % 4 != 0);
      if (out_read) k++;
    end
    @(negedge mclk);
    out_read = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : unload
endmodule : fft_user_model

// ### bench/complex_fft_256_engine_bench.sv
// Purpose: self-checking bench for the 256-point transform engine
// Assumes: ce high but for one frozen edge per single run; frames with known result
// Notes:   dc frames avoid twiddle rounding, tones are judged with a margin
`timescale 1ns/1ns
module complex_fft_256_engine_bench;
  logic        mclk, nrst, ce, start, direction_select, scale_select;
  logic [1:0]  io_mode, bank;
  logic        in_write, out_read, dout_valid, in_ready, busy, done, mode_latch;
  logic [15:0] din_r, din_i, dout_r, dout_i, c_r, c_i, amp;
  logic [7:0]  dout_index, in_index;
  int          n_errors, num_checks, cyc, n;

  fft256_engine u_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .start(start),
    .direction_select(direction_select), .scale_select(scale_select), .io_mode(io_mode),
    .in_write(in_write), .din_r(din_r), .din_i(din_i), .out_read(out_read),
    .dout_r(dout_r), .dout_i(dout_i), .dout_index(dout_index), .dout_valid(dout_valid),
    .in_index(in_index), .in_ready(in_ready), .busy(busy), .done(done),
    .mode_latch(mode_latch), .bank(bank));

  fft_user_model u_user (.mclk(mclk), .in_ready(in_ready), .dout_r(dout_r),
    .dout_i(dout_i), .dout_index(dout_index), .dout_valid(dout_valid),
    .in_write(in_write), .din_r(din_r), .din_i(din_i), .out_read(out_read));

  always #25 mclk = ~mclk;

  // about 24k cycles expected; generous margin
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    num_checks++;
    if (seen !== expv) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  // twiddles are rounded, so tones get a small margin
  task automatic near(input logic [15:0] seen, input int expv);
    logic signed [31:0] d;
    // four-state on purpose, so an unknown result cannot slip through
    d = $signed(seen) - expv;
    check(16'(d <= 16 && d >= -16), 16'h1);
  endtask : near

  function automatic logic [15:0] exp_dc(input int k, input logic [15:0] v, input logic s);
    return (k != 0) ? 16'h0 : (s ? {v[15], v[15:1]} : v);
  endfunction : exp_dc

  task automatic fill(input logic [15:0] r, input logic [15:0] i, input int a);
    for (int k = 0; k < 256; k++) begin
      u_user.fr[k] = a ? 16'(int'(a * $cos(6.283185307 * k / 256))) : r;
      u_user.fi[k] = a ? 16'(int'(a * $sin(6.283185307 * k / 256))) : i;
    end
  endtask : fill

  task automatic run_single(input logic dir, input logic scl);
    io_mode          = fft_pkg::MODE_SINGLE;
    direction_select = dir;
    scale_select     = scl;
    u_user.load();
    check({8'h0, in_index}, 16'h0);
    start = 1'b1;
    @(negedge mclk);
    start            = 1'b0;
    direction_select = ~dir;
    scale_select     = ~scl;
    check({15'h0, busy}, 16'h1);
    check({15'h0, in_ready}, 16'h0);
    n = 0;
    while (busy) begin
      n++;
      // one frozen edge mid-transform stretches busy by a cycle
      ce = (n != 1000);
      @(negedge mclk);
    end
    check(16'(n), 16'h801);
    check({15'h0, done}, 16'h1);
    u_user.unload();
    check(16'(u_user.nres), 16'h100);
  endtask : run_single

  task automatic wait_latch();
    n = 0;
    while (!mode_latch && n < 5000) begin
      n++;
      @(negedge mclk);
    end
    check({15'h0, mode_latch}, 16'h1);
    check({15'h0, busy}, 16'h1);
  endtask : wait_latch

  initial begin
    mclk = 0; nrst = 0; ce = 1; start = 0; direction_select = 1; scale_select = 0;
    io_mode = 2'h0; n_errors = 0; num_checks = 0; cyc = 0;
    void'($urandom(32'hafcdf88f));
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    // every direction and scale setting on a dc frame, most negative value first
    for (int m = 0; m < 4; m++) begin
      c_r = (m == 0) ? 16'h8000 : 16'($urandom) & 16'hfffe;
      c_i = 16'($urandom) & 16'hfffe;
      fill(c_r, c_i, 0);
      run_single(m[0], m[1]);
      for (int k = 0; k < 256; k++) begin
        check({8'h0, u_user.ix[k]}, 16'(k));
        check(u_user.rr[k], exp_dc(k, c_r, m[1]));
        check(u_user.ri[k], exp_dc(k, c_i, m[1]));
      end
    end
    // a rising tone lands in bin 1 forward and in bin 255 inverse
    for (int m = 0; m < 2; m++) begin
      amp = 16'(3000 + $urandom % 3000);
      fill(16'h0, 16'h0, amp);
      run_single(m[0], 1'b0);
      for (int k = 0; k < 256; k++) begin
        near(u_user.rr[k], (k == (m ? 1 : 255)) ? int'(amp) : 0);
        near(u_user.ri[k], 0);
      end
    end
    // triple arrangement: load next frame while the engine computes
    io_mode      = fft_pkg::MODE_TRIPLE;
    scale_select = 1'b0;
    start        = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    fill(16'h0400, 16'hfc00, 0);
    u_user.load();
    wait_latch();
    check({14'h0, bank}, {14'h0, fft_pkg::BANK_A});
    scale_select = 1'b1;
    fill(16'h0600, 16'h0200, 0);
    u_user.load();
    check({15'h0, busy}, 16'h1);
    wait_latch();
    check({14'h0, bank}, {14'h0, fft_pkg::BANK_C});
    u_user.unload();
    check(u_user.rr[0], 16'h0400);
    check(u_user.ri[0], 16'hfc00);
    fill(16'h0, 16'h0, 0);
    u_user.load();
    wait_latch();
    check({14'h0, bank}, {14'h0, fft_pkg::BANK_B});
    u_user.unload();
    check(u_user.rr[0], 16'h0300);
    check(u_user.ri[0], 16'h0100);
    // continuous runs end only by reset; then the double arrangement
    nrst = 1'b0;
    @(negedge mclk);
    check({15'h0, busy}, 16'h0);
    check({8'h0, in_index}, 16'h0);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    io_mode      = fft_pkg::MODE_DOUBLE;
    scale_select = 1'b0;
    start        = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    fill(16'h0a00, 16'hf600, 0);
    u_user.load();
    wait_latch();
    check({14'h0, bank}, {14'h0, fft_pkg::BANK_A});
    fill(16'h0, 16'h0, 0);
    u_user.load();
    wait_latch();
    check({14'h0, bank}, {14'h0, fft_pkg::BANK_B});
    u_user.unload();
    check(u_user.rr[0], 16'h0a00);
    check(u_user.ri[0], 16'hf600);
    finish_test();
  end
endmodule : complex_fft_256_engine_bench
